// ### osc_sysclk_select.sv
// Purpose: Oscillator enables, stabilization waits and glitch-free system clock source select
// Assumes: Oscillator outputs arrive as pins and are sampled on ref_clk; sleepMode is synchronous
// Notes:   sysClkSel is one-hot by source code; the analog mux cell follows it
//
// The Avalon-MM register port and the placing of the registers were left to the implementer.

// Overview of operation
// - Fast crystal runs while its enable is set; stops when cleared or in sleep.
// - Fast crystal enable resets to 1 on two-oscillator, 0 on three-oscillator variant.
// - Fast crystal clock held from system until its wait count elapses after start.
// - Fast wait select: 3=128, 2=256, 1=512, 0=1024 cycles; resets to 0.
// - Fast wait enable resets to 1; writing 0 bypasses the stabilization wait.
// - Slow oscillator runs while its enable is set; stops when cleared or in sleep.
// - Slow oscillator enable resets to 0 on both variants.
// - Slow oscillator has fixed 256-cycle stabilization wait before reaching system.
// - Slow wait enable resets to 1; writing 0 passes clock immediately.
// - Internal frequency select: 3=2, 2=4, 1=12, 0=8 MHz; resets to 1.
// - Internal oscillator enable resets to 1 on three-oscillator, 0 on two-oscillator variant; cleared or sleep stops it.
// - On sleep exit, three-oscillator variant forces internal on and selects it.
// - Internal clock held from system until its wait count elapses after start.
// - Internal wait select: 3=8, 2=16, 1=32, 0=64 cycles; resets to 0.
// - Source select: 2=fast, 1=slow, 0=internal (three only); 3 reserved.
// - Reset source is fast crystal on two-osc, internal on three-osc variant.
// - Source write naming a stopped oscillator is ignored; field keeps old value.
// - Selected source oscillator cannot be stopped by a write; disabling writes have no effect.
// - Leaving halt changes no enable or source setting.
module osc_sysclk_select #(
  parameter bit THREE_OSC = 1'b1
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Avalon-MM slave
  input wire osc_clk_pkg::avmm_req_t avsReq,
  output logic waitrequest,
  output logic [31:0] readdata,
  // Oscillator outputs from the pins
  input wire logic rcOscClk,
  input wire logic slowOscClk,
  input wire logic fastOscClk,
  // Power state from the core
  input wire logic sleepMode,
  // Oscillator run controls
  output logic fastOscRun,
  output logic slowOscRun,
  output logic rcOscRun,
  output logic [1:0] rcFreqSel,
  // System clock mux control
  output logic [2:0] sysClkSel,
  output logic sysClkReady
);

  // Reset values that depend on the variant
  localparam logic FAST_EN_RST =
    THREE_OSC ? osc_clk_pkg::RST_FAST_EN_THREE : osc_clk_pkg::RST_FAST_EN_TWO;
  localparam logic RC_EN_RST = THREE_OSC ? osc_clk_pkg::RST_RC_EN_THREE : 1'b0;
  localparam osc_clk_pkg::clk_src_t SRC_RST =
    THREE_OSC ? osc_clk_pkg::SRC_INTERNAL : osc_clk_pkg::SRC_FAST;

  // Configuration state
  osc_clk_pkg::osc_ctrl_t ctrl_q, ctrl_d;
  logic fastWaitEn_q, fastWaitEn_d;
  logic slowWaitEn_q, slowWaitEn_d;
  logic [1:0] rcFreq_q, rcFreq_d;
  osc_clk_pkg::clk_src_t srcSel_q, srcSel_d;
  logic sleepPrev_q, sleepPrev_d;

  // Bus state
  logic wait_q, wait_d;
  logic [31:0] rdata_q, rdata_d;

  // Oscillator sampling and stabilization state, index = source code
  logic [2:0] sync1_q, sync2_q, sync3_q;
  logic [2:0] run_q, run_d;
  logic [2:0] done_q, done_d;
  logic [osc_clk_pkg::CNT_W-1:0] cnt_q [3];
  logic [osc_clk_pkg::CNT_W-1:0] cnt_d [3];

  // Mux state
  osc_clk_pkg::clk_src_t active_q, active_d;
  logic [2:0] selOut_q, selOut_d;
  logic clkReady_q, clkReady_d;

  // Shared combinational terms
  logic [2:0] enVec;
  logic [2:0] ready;
  logic [2:0] waitOn;
  logic [osc_clk_pkg::CNT_W-1:0] target [3];
  logic wrHit;
  logic rdHit;
  logic [7:0] wd;
  logic pending;

  assign enVec = {ctrl_q.fastEn, ctrl_q.slowEn, ctrl_q.rcEn};
  assign wrHit = avsReq.write && !wait_q && avsReq.byteenable[0];
  assign rdHit = avsReq.read && wait_q;
  assign wd = avsReq.writedata[7:0];
  assign pending = (srcSel_q != active_q);
  // Internal oscillator has no bypass bit, its wait is always applied
  assign waitOn = {fastWaitEn_q, slowWaitEn_q, 1'b1};

  // Stabilization targets from the wait selects
  always_comb begin
    unique case (ctrl_q.fastWaitSel)
      2'h0: target[2] = osc_clk_pkg::FAST_WAIT_SEL0;
      2'h1: target[2] = osc_clk_pkg::FAST_WAIT_SEL1;
      2'h2: target[2] = osc_clk_pkg::FAST_WAIT_SEL2;
      2'h3: target[2] = osc_clk_pkg::FAST_WAIT_SEL3;
    endcase
    target[1] = osc_clk_pkg::SLOW_WAIT;
    unique case (ctrl_q.rcWaitSel)
      2'h0: target[0] = osc_clk_pkg::RC_WAIT_SEL0;
      2'h1: target[0] = osc_clk_pkg::RC_WAIT_SEL1;
      2'h2: target[0] = osc_clk_pkg::RC_WAIT_SEL2;
      2'h3: target[0] = osc_clk_pkg::RC_WAIT_SEL3;
    endcase
  end

  // Configuration next state; halt is not an input, so nothing here reacts to it
  always_comb begin
    ctrl_d = ctrl_q;
    fastWaitEn_d = fastWaitEn_q;
    slowWaitEn_d = slowWaitEn_q;
    rcFreq_d = rcFreq_q;
    srcSel_d = srcSel_q;
    sleepPrev_d = sleepMode;
    if (wrHit) begin
      unique case (avsReq.address)
        osc_clk_pkg::OFS_SOURCE: begin
          // Reserved codes and stopped oscillators leave the field alone
          if (wd[1:0] != osc_clk_pkg::SRC_RESERVED
              && (THREE_OSC || wd[1:0] != osc_clk_pkg::SRC_INTERNAL)
              && enVec[wd[1:0]]) begin
            srcSel_d = osc_clk_pkg::clk_src_t'(wd[1:0]);
          end
        end
        osc_clk_pkg::OFS_CONTROL: begin
          // Selected or still-active source keeps running
          ctrl_d.fastEn = wd[osc_clk_pkg::CTL_FAST_EN]
            || srcSel_q == osc_clk_pkg::SRC_FAST || active_q == osc_clk_pkg::SRC_FAST;
          ctrl_d.slowEn = wd[osc_clk_pkg::CTL_SLOW_EN]
            || srcSel_q == osc_clk_pkg::SRC_SLOW || active_q == osc_clk_pkg::SRC_SLOW;
          ctrl_d.rcEn = THREE_OSC && (wd[osc_clk_pkg::CTL_RC_EN]
            || srcSel_q == osc_clk_pkg::SRC_INTERNAL
            || active_q == osc_clk_pkg::SRC_INTERNAL);
          ctrl_d.fastWaitSel = wd[osc_clk_pkg::CTL_FAST_WAIT_LO +: 2];
          ctrl_d.rcWaitSel = wd[osc_clk_pkg::CTL_RC_WAIT_LO +: 2];
        end
        osc_clk_pkg::OFS_WAIT_EN: begin
          fastWaitEn_d = wd[osc_clk_pkg::WEN_FAST];
          slowWaitEn_d = wd[osc_clk_pkg::WEN_SLOW];
        end
        osc_clk_pkg::OFS_RC_CTRL: begin
          if (THREE_OSC) begin
            rcFreq_d = wd[1:0];
          end
        end
        default: begin
          // Status and unmapped offsets ignore writes
        end
      endcase
    end
    // Quick restart on wake overrides a same-cycle write to the internal enable or the source select
    if (THREE_OSC && sleepPrev_q && !sleepMode) begin
      ctrl_d.rcEn = 1'b1;
      srcSel_d = osc_clk_pkg::SRC_INTERNAL;
    end
  end

  // Configuration registers
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ctrl_q.fastEn <= FAST_EN_RST;
      ctrl_q.slowEn <= osc_clk_pkg::RST_SLOW_EN;
      ctrl_q.rcEn <= RC_EN_RST;
      ctrl_q.fastWaitSel <= osc_clk_pkg::RST_FAST_WAIT_SEL;
      ctrl_q.rcWaitSel <= osc_clk_pkg::RST_RC_WAIT_SEL;
      fastWaitEn_q <= osc_clk_pkg::RST_WAIT_EN;
      slowWaitEn_q <= osc_clk_pkg::RST_WAIT_EN;
      rcFreq_q <= osc_clk_pkg::RST_RC_FREQ_SEL;
      srcSel_q <= SRC_RST;
      sleepPrev_q <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      fastWaitEn_q <= fastWaitEn_d;
      slowWaitEn_q <= slowWaitEn_d;
      rcFreq_q <= rcFreq_d;
      srcSel_q <= srcSel_d;
      sleepPrev_q <= sleepPrev_d;
    end
  end

  // Pin samplers; sync1 feeds only sync2, sync3 is the previous level for edge counting
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sync1_q <= 3'h0;
      sync2_q <= 3'h0;
      sync3_q <= 3'h0;
    end else begin
      sync1_q <= {fastOscClk, slowOscClk, rcOscClk};
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end

  // Run controls and stabilization counters
  always_comb begin
    // Sleep stops every oscillator regardless of its enable
    run_d = enVec & {3{!sleepMode}};
    for (int i = 0; i < 3; i++) begin
      cnt_d[i] = cnt_q[i];
      done_d[i] = done_q[i];
      if (!run_q[i]) begin
        // Stopped oscillator: next start counts again from zero
        cnt_d[i] = '0;
        done_d[i] = 1'b0;
      end else if (sync2_q[i] && !sync3_q[i] && !done_q[i]) begin
        cnt_d[i] = cnt_q[i] + 1'b1;
        done_d[i] = (cnt_q[i] + 1'b1 == target[i]);
      end
    end
  end

  // A clock is usable once running and past its wait, or its wait is bypassed
  assign ready = run_q & (done_q | ~waitOn);

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      run_q <= 3'h0;
      done_q <= 3'h0;
      for (int i = 0; i < 3; i++) begin
        cnt_q[i] <= '0;
      end
    end else begin
      run_q <= run_d;
      done_q <= done_d;
      for (int i = 0; i < 3; i++) begin
        cnt_q[i] <= cnt_d[i];
      end
    end
  end

  // Glitch-free changeover: wait for new clock ready and sampled low, and old clock stopped or sampled low
  always_comb begin
    active_d = active_q;
    if (pending && ready[srcSel_q] && !sync2_q[srcSel_q]
        && (!run_q[active_q] || !sync2_q[active_q])) begin
      active_d = srcSel_q;
    end
    selOut_d = 3'h0;
    selOut_d[active_d] = 1'b1;
    // Sampled low level trails the pin by two cycles; the mux cell must tolerate it
    clkReady_d = ready[active_d] && !sleepMode;
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      active_q <= SRC_RST;
      selOut_q <= 3'h0;
      clkReady_q <= 1'b0;
    end else begin
      active_q <= active_d;
      selOut_q <= selOut_d;
      clkReady_q <= clkReady_d;
    end
  end

  // Bus answer: one wait cycle for every access, read data loaded with it
  always_comb begin
    wait_d = 1'b1;
    rdata_d = rdata_q;
    if ((avsReq.read || avsReq.write) && wait_q) begin
      wait_d = 1'b0;
    end
    if (rdHit) begin
      rdata_d = 32'h0000_0000;
      unique case (avsReq.address)
        osc_clk_pkg::OFS_SOURCE: rdata_d[1:0] = srcSel_q;
        osc_clk_pkg::OFS_CONTROL: begin
          rdata_d[osc_clk_pkg::CTL_FAST_EN] = ctrl_q.fastEn;
          rdata_d[osc_clk_pkg::CTL_SLOW_EN] = ctrl_q.slowEn;
          rdata_d[osc_clk_pkg::CTL_RC_EN] = ctrl_q.rcEn;
          rdata_d[osc_clk_pkg::CTL_FAST_WAIT_LO +: 2] = ctrl_q.fastWaitSel;
          rdata_d[osc_clk_pkg::CTL_RC_WAIT_LO +: 2] = ctrl_q.rcWaitSel;
        end
        osc_clk_pkg::OFS_WAIT_EN: begin
          rdata_d[osc_clk_pkg::WEN_FAST] = fastWaitEn_q;
          rdata_d[osc_clk_pkg::WEN_SLOW] = slowWaitEn_q;
        end
        osc_clk_pkg::OFS_RC_CTRL: rdata_d[1:0] = rcFreq_q;
        osc_clk_pkg::OFS_STATUS: begin
          rdata_d[2:0] = ready;
          rdata_d[osc_clk_pkg::STA_ACTIVE_LO +: 2] = active_q;
          rdata_d[osc_clk_pkg::STA_PENDING] = pending;
        end
        default: rdata_d = 32'h0000_0000; // Unmapped reads as zero
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      wait_q <= 1'b1;
      rdata_q <= 32'h0000_0000;
    end else begin
      wait_q <= wait_d;
      rdata_q <= rdata_d;
    end
  end

  // Outputs straight from flip-flops
  assign waitrequest = wait_q;
  assign readdata = rdata_q;
  assign rcOscRun = run_q[0];
  assign slowOscRun = run_q[1];
  assign fastOscRun = run_q[2];
  assign rcFreqSel = rcFreq_q;
  assign sysClkSel = selOut_q;
  assign sysClkReady = clkReady_q;

endmodule : osc_sysclk_select

// ### osc_clk_pkg.sv
// Purpose: Shared constants and types for the oscillator and system clock select block
// Assumes: 32-bit Avalon-MM register bus, byte addresses, one word per register
// Notes:   Oscillator index equals its system clock source code
package osc_clk_pkg;

  // Register byte offsets
  localparam int unsigned ADDR_W = 5;
  localparam logic [ADDR_W-1:0] OFS_SOURCE = 5'h00;
  localparam logic [ADDR_W-1:0] OFS_CONTROL = 5'h04;
  localparam logic [ADDR_W-1:0] OFS_WAIT_EN = 5'h08;
  localparam logic [ADDR_W-1:0] OFS_RC_CTRL = 5'h0C;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 5'h10;

  // Field positions in the control register
  localparam int unsigned CTL_FAST_EN = 0;
  localparam int unsigned CTL_SLOW_EN = 1;
  localparam int unsigned CTL_RC_EN = 2;
  localparam int unsigned CTL_FAST_WAIT_LO = 4;
  localparam int unsigned CTL_RC_WAIT_LO = 6;
  // Field positions in the wait enable register
  localparam int unsigned WEN_FAST = 0;
  localparam int unsigned WEN_SLOW = 1;
  // Field positions in the status register
  localparam int unsigned STA_ACTIVE_LO = 4;
  localparam int unsigned STA_PENDING = 6;

  // System clock source codes, also the oscillator index
  typedef enum logic [1:0] {
    SRC_INTERNAL = 2'b00,
    SRC_SLOW = 2'b01,
    SRC_FAST = 2'b10,
    SRC_RESERVED = 2'b11
  } clk_src_t;

  // Values after reset
  localparam logic [1:0] RST_FAST_WAIT_SEL = 2'h0;
  localparam logic [1:0] RST_RC_WAIT_SEL = 2'h0;
  localparam logic [1:0] RST_RC_FREQ_SEL = 2'h1;
  localparam logic RST_FAST_EN_TWO = 1'b1;
  localparam logic RST_FAST_EN_THREE = 1'b0;
  localparam logic RST_SLOW_EN = 1'b0;
  localparam logic RST_RC_EN_THREE = 1'b1;
  localparam logic RST_WAIT_EN = 1'b1;

  // Stabilization counts in oscillator cycles
  localparam int unsigned CNT_W = 11;
  localparam logic [CNT_W-1:0] FAST_WAIT_SEL0 = 11'h400;
  localparam logic [CNT_W-1:0] FAST_WAIT_SEL1 = 11'h200;
  localparam logic [CNT_W-1:0] FAST_WAIT_SEL2 = 11'h100;
  localparam logic [CNT_W-1:0] FAST_WAIT_SEL3 = 11'h080;
  localparam logic [CNT_W-1:0] SLOW_WAIT = 11'h100;
  localparam logic [CNT_W-1:0] RC_WAIT_SEL0 = 11'h040;
  localparam logic [CNT_W-1:0] RC_WAIT_SEL1 = 11'h020;
  localparam logic [CNT_W-1:0] RC_WAIT_SEL2 = 11'h010;
  localparam logic [CNT_W-1:0] RC_WAIT_SEL3 = 11'h008;

  // Avalon-MM request group
  typedef struct packed {
    logic read;
    logic write;
    logic [ADDR_W-1:0] address;
    logic [31:0] writedata;
    logic [3:0] byteenable;
  } avmm_req_t;

  // Oscillator control fields
  typedef struct packed {
    logic fastEn;
    logic slowEn;
    logic rcEn;
    logic [1:0] fastWaitSel;
    logic [1:0] rcWaitSel;
  } osc_ctrl_t;

endpackage : osc_clk_pkg

// ### osc_pads_model.sv
// Purpose: Behavioural oscillators on the far side of the clock select block
// Assumes: Periods of at least four reference cycles so the samplers see every edge
// Notes: A stopped oscillator sits low, as a halted resonator would
module osc_pads_model (
  // Run controls from the block
  input wire logic fastRun,
  input wire logic slowRun,
  input wire logic rcRun,
  // Oscillator outputs
  output logic fastClk,
  output logic slowClk,
  output logic rcClk
);
  timeunit 1ns;
  timeprecision 1ns;

  // Each output toggles only while its run control is high
  initial begin
    fastClk = 1'b0;
    slowClk = 1'b0;
    rcClk = 1'b0;
  end
  always #150 fastClk = fastRun ? ~fastClk : 1'b0;
  always #200 slowClk = slowRun ? ~slowClk : 1'b0;
  always #100 rcClk = rcRun ? ~rcClk : 1'b0;
endmodule : osc_pads_model

// ### osc_sysclk_select_props.sv
// Purpose: Port-level checks on the clock select block
// Assumes: One clock domain, reset active high
// Notes: Bound to every instance of the block
module osc_sysclk_select_props (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Bus side
  input wire osc_clk_pkg::avmm_req_t avsReq,
  input wire logic waitrequest,
  // Oscillator side
  input wire logic sleepMode,
  input wire logic fastOscRun,
  input wire logic slowOscRun,
  input wire logic rcOscRun,
  input wire logic [1:0] rcFreqSel,
  input wire logic [2:0] sysClkSel,
  input wire logic sysClkReady
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);

  // Completed write to the internal oscillator register
  logic rcWr;
  assign rcWr = avsReq.write && !waitrequest && avsReq.byteenable[0]
    && avsReq.address == osc_clk_pkg::OFS_RC_CTRL;

  a_one_wait: assert property ($fell(waitrequest) |=> waitrequest)
    else $error("waitrequest low for more than one cycle");
  a_sleep_stops: assert property (sleepMode |=> !fastOscRun && !slowOscRun && !rcOscRun)
    else $error("oscillator still running in sleep");
  a_src_onehot: assert property ($onehot(sysClkSel) || $past(rst))
    else $error("system clock select not one-hot");
  a_rc_kept: assert property (sysClkSel[0] && !$past(sleepMode) |-> rcOscRun)
    else $error("selected internal oscillator stopped");
  a_fast_kept: assert property (sysClkSel[2] && !$past(sleepMode) |-> fastOscRun)
    else $error("selected fast oscillator stopped");
  a_slow_kept: assert property (sysClkSel[1] && !$past(sleepMode) |-> slowOscRun)
    else $error("selected slow oscillator stopped");
  a_rc_stab: assert property ($rose(rcOscRun) && sysClkSel[0] |-> !sysClkReady [*8])
    else $error("internal clock ready before its wait");
  a_fast_stab: assert property ($rose(fastOscRun) && sysClkSel[2] |-> !sysClkReady [*8])
    else $error("fast clock ready before its wait");
  a_sleep_unready: assert property (sleepMode [*2] |=> !sysClkReady)
    else $error("system clock ready during sleep");
  a_freq_cause: assert property ($changed(rcFreqSel) |-> $past(rcWr) || $past(rcWr, 2))
    else $error("frequency select changed without a write");

  // Main scenarios reached
  c_slow_sel: cover property (sysClkSel == 3'b010);
  c_fast_sel: cover property ($rose(sysClkSel[2]));
  c_wake: cover property ($fell(sleepMode) ##[1:600] sysClkSel[0]);
endmodule : osc_sysclk_select_props

bind osc_sysclk_select osc_sysclk_select_props chk (.ref_clk(ref_clk), .rst(rst),
  .avsReq(avsReq), .waitrequest(waitrequest), .sleepMode(sleepMode),
  .fastOscRun(fastOscRun), .slowOscRun(slowOscRun), .rcOscRun(rcOscRun),
  .rcFreqSel(rcFreqSel), .sysClkSel(sysClkSel), .sysClkReady(sysClkReady));

// ### oscillator_sysclk_select_bench.sv
// Purpose: Register and clock switching tests of both variants side by side
// Assumes: Both variants share the bus request; bus timing taken from the first
// Notes: Second variant checked through its read data and its run controls in sleep
module oscillator_sysclk_select_bench;
  timeunit 1ns;
  timeprecision 1ns;

  logic ref_clk;
  logic rst;
  logic sleepMode;
  osc_clk_pkg::avmm_req_t req;
  logic waitrequest;
  logic [31:0] rdA;
  logic [31:0] rdB;
  logic [2:0] runA;
  logic [2:0] runB;
  logic [2:0] padA;
  logic [2:0] padB;
  logic [1:0] rcFreqSel;
  logic [2:0] sysClkSel;
  logic clkReady;
  int num_errors = 0;
  int samples_checked = 0;
  int cycles = 0;

  osc_sysclk_select #(.THREE_OSC(1'b1)) uut (.ref_clk(ref_clk), .rst(rst), .avsReq(req),
    .waitrequest(waitrequest), .readdata(rdA), .rcOscClk(padA[0]), .slowOscClk(padA[1]),
    .fastOscClk(padA[2]), .sleepMode(sleepMode), .fastOscRun(runA[2]), .slowOscRun(runA[1]),
    .rcOscRun(runA[0]), .rcFreqSel(rcFreqSel), .sysClkSel(sysClkSel), .sysClkReady(clkReady));
  osc_sysclk_select #(.THREE_OSC(1'b0)) uutTwo (.ref_clk(ref_clk), .rst(rst), .avsReq(req),
    .waitrequest(), .readdata(rdB), .rcOscClk(padB[0]), .slowOscClk(padB[1]),
    .fastOscClk(padB[2]), .sleepMode(sleepMode), .fastOscRun(runB[2]), .slowOscRun(runB[1]),
    .rcOscRun(runB[0]), .rcFreqSel(), .sysClkSel(), .sysClkReady());
  osc_pads_model padsA (.fastRun(runA[2]), .slowRun(runA[1]), .rcRun(runA[0]),
    .fastClk(padA[2]), .slowClk(padA[1]), .rcClk(padA[0]));
  osc_pads_model padsB (.fastRun(runB[2]), .slowRun(runB[1]), .rcRun(runB[0]),
    .fastClk(padB[2]), .slowClk(padB[1]), .rcClk(padB[0]));

  // 20 MHz reference clock
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  // Cuts a hung run short
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    if (num_errors == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : give_verdict

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // One bus access; entered just after a rising edge, leaves one idle edge behind
  // Waitrequest and read data are taken at the rising edge; only the bench timeout ends a hang
  task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d,
                     output logic [31:0] seenA, output logic [31:0] seenB);
    req.write <= w;
    req.read <= !w;
    req.address <= a;
    req.writedata <= {24'h00_0000, d};
    do begin
      @(posedge ref_clk);
    end while (waitrequest !== 1'b0);
    seenA = rdA;
    seenB = rdB;
    req.read <= 1'b0;
    req.write <= 1'b0;
    @(posedge ref_clk);
  endtask : bus

  // Optional write, then read back from both variants
  task automatic acc(input int w, input logic [4:0] a, input logic [7:0] d,
                     input logic [7:0] eA, input logic [7:0] eB);
    logic [31:0] sA;
    logic [31:0] sB;
    if (w != 0) begin
      bus(1'b1, a, d, sA, sB);
    end
    bus(1'b0, a, 8'h00, sA, sB);
    chk("read three-osc", sA, {24'h00_0000, eA});
    chk("read two-osc", sB, {24'h00_0000, eB});
  endtask : acc

  // Waits a bounded time for a given source, then compares
  task automatic waitsel(input logic [2:0] v, input int maxc);
    int n;
    for (n = 0; n < maxc && sysClkSel !== v; n++) begin
      @(posedge ref_clk);
    end
    chk("sysClkSel", {29'h0000_0000, sysClkSel}, {29'h0000_0000, v});
  endtask : waitsel

  // Main sequence
  initial begin
    rst = 1'b1;
    sleepMode = 1'b0;
    req = '0;
    req.byteenable = 4'hf;
    repeat (20) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    acc(0, osc_clk_pkg::OFS_SOURCE, 8'h00, 8'h00, 8'h02);
    chk("ready before wait", {31'h0000_0000, clkReady}, 32'h0000_0000);
    acc(0, osc_clk_pkg::OFS_CONTROL, 8'h00, 8'h04, 8'h01);
    acc(0, osc_clk_pkg::OFS_WAIT_EN, 8'h00, 8'h03, 8'h03);
    acc(0, 5'h14, 8'h00, 8'h00, 8'h00);
    acc(1, osc_clk_pkg::OFS_SOURCE, 8'h01, 8'h00, 8'h02);
    acc(1, osc_clk_pkg::OFS_SOURCE, 8'h03, 8'h00, 8'h02);
    acc(1, osc_clk_pkg::OFS_SOURCE, 8'h00, 8'h00, 8'h02);
    acc(1, osc_clk_pkg::OFS_CONTROL, 8'h00, 8'h04, 8'h01);
    chk("rcOscRun", {31'h0000_0000, runA[0]}, 32'h0000_0001);
    for (int i = 3; i >= 0; i--) begin
      acc(1, osc_clk_pkg::OFS_RC_CTRL, 8'(i), 8'(i), 8'h01);
      chk("rcFreqSel", {30'h0000_0000, rcFreqSel}, 32'(i));
    end
    // Slow source after its fixed wait
    acc(1, osc_clk_pkg::OFS_CONTROL, 8'h06, 8'h06, 8'h03);
    acc(1, osc_clk_pkg::OFS_SOURCE, 8'h01, 8'h01, 8'h01);
    repeat (1880) @(posedge ref_clk);
    chk("slow wait pending", {29'h0000_0000, sysClkSel}, 32'h0000_0001);
    // Status: ready per source, active source, switch pending
    acc(0, osc_clk_pkg::OFS_STATUS, 8'h00, 8'h41, 8'h60);
    waitsel(3'b010, 400);
    // Fast source with its wait bypassed
    acc(1, osc_clk_pkg::OFS_WAIT_EN, 8'h02, 8'h02, 8'h02);
    acc(1, osc_clk_pkg::OFS_CONTROL, 8'h07, 8'h07, 8'h03);
    acc(1, osc_clk_pkg::OFS_SOURCE, 8'h02, 8'h02, 8'h02);
    waitsel(3'b100, 100);
    // Fast source restarted with the shortest wait
    acc(1, osc_clk_pkg::OFS_SOURCE, 8'h01, 8'h01, 8'h01);
    waitsel(3'b010, 100);
    acc(1, osc_clk_pkg::OFS_WAIT_EN, 8'h03, 8'h03, 8'h03);
    acc(1, osc_clk_pkg::OFS_CONTROL, 8'h32, 8'h32, 8'h32);
    acc(1, osc_clk_pkg::OFS_CONTROL, 8'h33, 8'h33, 8'h33);
    acc(1, osc_clk_pkg::OFS_SOURCE, 8'h02, 8'h02, 8'h02);
    repeat (720) @(posedge ref_clk);
    chk("fast wait pending", {29'h0000_0000, sysClkSel}, 32'h0000_0002);
    waitsel(3'b100, 300);
    // Sleep stops everything; wake forces the internal oscillator
    sleepMode <= 1'b1;
    repeat (10) @(posedge ref_clk);
    chk("runs in sleep", {29'h0000_0000, runA}, 32'h0000_0000);
    chk("runs in sleep two", {29'h0000_0000, runB}, 32'h0000_0000);
    chk("ready in sleep", {31'h0000_0000, clkReady}, 32'h0000_0000);
    sleepMode <= 1'b0;
    repeat (3) @(posedge ref_clk);
    chk("rcOscRun wake", {31'h0000_0000, runA[0]}, 32'h0000_0001);
    acc(0, osc_clk_pkg::OFS_SOURCE, 8'h00, 8'h00, 8'h02);
    acc(0, osc_clk_pkg::OFS_CONTROL, 8'h00, 8'h37, 8'h33);
    waitsel(3'b001, 600);
    chk("ready after wake", {31'h0000_0000, clkReady}, 32'h0000_0001);
    give_verdict();
  end
endmodule : oscillator_sysclk_select_bench
